// ### src/hscp_defs.svh
// Purpose: Constants for the host serial command parser.
// Assumes: Byte-wide receive stream, one byte per strobe.
// Notes: Offsets and counts are used by the parser and the acknowledge sender.
`ifndef HSCP_DEFS_SVH
`define HSCP_DEFS_SVH
`define HSCP_MAX_BIN_LEN 5'h16
`define HSCP_MIN_LEN 5'h02
`define HSCP_MAX_ASC_CHARS 6'h30
`define HSCP_CHAR_CR 8'h0D
`define HSCP_CHAR_LF 8'h0A
`define HSCP_ACK_LEN_BYTE 8'h02
`define HSCP_ACK_CODE_BYTE 8'h01
`define HSCP_CMD_RESET 8'h00
`define HSCP_CMD_CONFIG 8'h01
`define HSCP_CMD_LAST_STD 8'h0F
`define HSCP_CMD_FETCH 8'h40
`define HSCP_PROP_REPLY_ANYTIME 8'h09
`define HSCP_REPLY_DEFAULT 1'b1
`endif

// ### src/hscp_pkg.sv
// Purpose: Types shared by the host serial command parser.
// Assumes: Nothing beyond the constants header.
// Notes: State codes are written out so traces read the same everywhere.
package hscp_pkg;
  // Parser sequencing states.
  typedef enum logic [3:0] {
    HSCP_IDLE = 4'h0,
    HSCP_BIN = 4'h1,
    HSCP_ASC_HI = 4'h2,
    HSCP_ASC_LO = 4'h3,
    HSCP_ASC_CR = 4'h4,
    HSCP_ASC_LF = 4'h5,
    HSCP_DISPATCH = 4'h6,
    HSCP_WAIT = 4'h7,
    HSCP_ACK = 4'h8,
    HSCP_RESET = 4'h9
  } hscp_state_t;
endpackage

// ### src/hscp_hex_digit.sv
// Purpose: Turns one ASCII character into a hex nibble.
// Assumes: Purely combinational use inside the parser.
// Notes: Both letter cases are accepted.
`timescale 1ns/100ps
module hscp_hex_digit (
  // Character in.
  input wire logic [7:0] char_i,
  // Decoded nibble out.
  output logic [3:0] nibble_o,
  output logic is_hex_o
);
  // Map digits and both letter cases; anything else is flagged as not hex.
  always_comb begin
    nibble_o = 4'h0;
    is_hex_o = 1'b0;
    if (char_i >= 8'h30 && char_i <= 8'h39) begin
      nibble_o = char_i[3:0];
      is_hex_o = 1'b1;
    end else if ((char_i >= 8'h41 && char_i <= 8'h46) ||
                 (char_i >= 8'h61 && char_i <= 8'h66)) begin
      nibble_o = char_i[3:0] + 4'h9;
      is_hex_o = 1'b1;
    end
  end
endmodule

// ### src/hscp_ack_tx.sv
// Purpose: Sends the two-byte acknowledge reply on the transmit stream.
// Assumes: Transmit side uses a valid and ready handshake.
// Notes: A start while busy is ignored; the parser never does that.
`timescale 1ns/100ps
`include "hscp_defs.svh"
module hscp_ack_tx (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Control from the parser.
  input wire logic start_i,
  output logic done_o,
  // Transmit stream.
  input wire logic tx_ready_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o
);
  logic second; // High while the code byte is being offered.
  logic next_second;
  logic next_done;
  logic [7:0] next_data;
  logic next_valid;

  // Step through length byte then code byte, one per accepted handshake.
  always_comb begin
    next_second = second;
    next_done = 1'b0;
    next_data = tx_data_o;
    next_valid = tx_valid_o;
    if (!tx_valid_o) begin
      if (start_i) begin
        next_valid = 1'b1;
        next_data = `HSCP_ACK_LEN_BYTE;
        next_second = 1'b0;
      end
    end else if (tx_ready_i) begin
      if (!second) begin
        next_data = `HSCP_ACK_CODE_BYTE;
        next_second = 1'b1;
      end else begin
        next_valid = 1'b0;
        next_second = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  // Register the sender state.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      second <= 1'b0;
      done_o <= 1'b0;
      tx_data_o <= 8'h00;
      tx_valid_o <= 1'b0;
    end else begin
      second <= next_second;
      done_o <= next_done;
      tx_data_o <= next_data;
      tx_valid_o <= next_valid;
    end
  end

  // The first byte offered after a start is always the length byte.
  AST_ACK_FIRST: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(tx_valid_o) |-> tx_data_o == `HSCP_ACK_LEN_BYTE)
    else $error("Acknowledge did not open with its length byte.");
endmodule

// ### src/hscp_parser.sv
// Purpose: Frames, checks and dispatches host serial commands.
// Assumes: One received byte per rx_valid_i pulse; handler obeys the handshake.
// Notes: Command payloads are read back by the handler over rd_addr_i.
`timescale 1ns/100ps
`include "hscp_defs.svh"
module hscp_parser
  import hscp_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Receive stream from the UART.
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_valid_i,
  // Command handler side.
  input wire logic handler_done_i,
  input wire logic handler_replied_i,
  input wire logic [4:0] rd_addr_i,
  output logic cmd_valid_o,
  output logic [7:0] cmd_code_o,
  output logic [4:0] cmd_len_o,
  output logic [7:0] rd_data_o,
  output logic reply_anytime_o,
  output logic soft_reset_o,
  // Flow control and reply stream.
  output logic rts_o,
  input wire logic tx_ready_i,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o
);
  hscp_state_t state; // Current parser state.
  hscp_state_t next_state;
  logic [7:0] msg_mem [0:21]; // Decoded message bytes.
  logic [4:0] byte_cnt; // Decoded bytes so far.
  logic [4:0] next_byte_cnt;
  logic [5:0] char_cnt; // ASCII characters so far.
  logic [5:0] next_char_cnt;
  logic [4:0] msg_len; // Length byte of the message.
  logic [4:0] next_msg_len;
  logic [3:0] hi_nib; // Upper digit waiting for its partner.
  logic [3:0] next_hi_nib;
  logic pending_ack; // Acknowledge held back for a fetch.
  logic next_pending_ack;
  logic next_reply_anytime;
  logic next_cmd_valid;
  logic [7:0] next_cmd_code;
  logic [4:0] next_cmd_len;
  logic next_soft_reset;
  logic next_rts;
  logic ack_start; // One-cycle kick to the acknowledge sender.
  logic next_ack_start;
  logic ack_done; // Sender finished both bytes.
  logic wr_en; // Store one decoded byte.
  logic [7:0] wr_data;
  logic [3:0] rx_nib; // Received character as a nibble.
  logic rx_hex; // Received character is a hex digit.
  logic [7:0] asc_byte; // Byte assembled from two digits.

  // Codes handed to the outside handler; reset, fetch and unknown codes are not.
  function automatic logic is_handler_code(input logic [7:0] code);
    is_handler_code = (code != `HSCP_CMD_RESET) && (code <= `HSCP_CMD_LAST_STD);
  endfunction

  // A length byte is usable when it covers at least length and code bytes and at most 22 bytes.
  function automatic logic len_ok(input logic [7:0] len);
    len_ok = (len >= {3'h0, `HSCP_MIN_LEN}) && (len <= {3'h0, `HSCP_MAX_BIN_LEN});
  endfunction

  // RTS covers every state in which a command is owned by the device.
  function automatic logic is_busy(input hscp_state_t st);
    is_busy = (st == HSCP_DISPATCH) || (st == HSCP_WAIT) ||
              (st == HSCP_ACK) || (st == HSCP_RESET);
  endfunction

  hscp_hex_digit u_hex (
    .char_i(rx_byte_i),
    .nibble_o(rx_nib),
    .is_hex_o(rx_hex)
  );

  hscp_ack_tx u_ack (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .start_i(ack_start),
    .done_o(ack_done),
    .tx_ready_i(tx_ready_i),
    .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o)
  );

  assign asc_byte = {hi_nib, rx_nib};

  // Next-state logic for framing, dispatch and reply decisions.
  always_comb begin
    next_state = state;
    next_byte_cnt = byte_cnt;
    next_char_cnt = char_cnt;
    next_msg_len = msg_len;
    next_hi_nib = hi_nib;
    next_pending_ack = pending_ack;
    next_reply_anytime = reply_anytime_o;
    next_cmd_valid = 1'b0;
    next_cmd_code = cmd_code_o;
    next_cmd_len = cmd_len_o;
    next_soft_reset = 1'b0;
    next_ack_start = 1'b0;
    wr_en = 1'b0;
    wr_data = rx_byte_i;
    case (state)
      HSCP_IDLE: begin
        // The first byte alone decides binary or ASCII; hex characters
        // never fall in the legal binary length range.
        if (rx_valid_i) begin
          next_byte_cnt = 5'h00;
          next_char_cnt = 6'h00;
          if (rx_byte_i == 8'h00) begin
            next_state = HSCP_RESET;
          end else if (len_ok(rx_byte_i)) begin
            wr_en = 1'b1;
            next_msg_len = rx_byte_i[4:0];
            next_byte_cnt = 5'h01;
            next_state = HSCP_BIN;
          end else if (rx_hex) begin
            next_hi_nib = rx_nib;
            next_char_cnt = 6'h01;
            next_state = HSCP_ASC_LO;
          end
        end
      end
      HSCP_BIN: begin
        // Collect until the count reaches the length byte.
        if (rx_valid_i) begin
          wr_en = 1'b1;
          next_byte_cnt = byte_cnt + 5'h01;
          if (next_byte_cnt == msg_len) begin
            next_state = HSCP_DISPATCH;
          end
        end
      end
      HSCP_ASC_HI: begin
        // Upper digit; anything else or an overlong line drops the message.
        if (rx_valid_i) begin
          next_char_cnt = char_cnt + 6'h01;
          if (!rx_hex || char_cnt >= `HSCP_MAX_ASC_CHARS) begin
            next_state = HSCP_IDLE;
          end else begin
            next_hi_nib = rx_nib;
            next_state = HSCP_ASC_LO;
          end
        end
      end
      HSCP_ASC_LO: begin
        // Lower digit completes a byte.
        if (rx_valid_i) begin
          next_char_cnt = char_cnt + 6'h01;
          if (!rx_hex) begin
            next_state = HSCP_IDLE;
          end else if (byte_cnt == 5'h00 && asc_byte == 8'h00) begin
            next_state = HSCP_RESET;
          end else if (byte_cnt == 5'h00 && !len_ok(asc_byte)) begin
            next_state = HSCP_IDLE;
          end else begin
            wr_en = 1'b1;
            wr_data = asc_byte;
            if (byte_cnt == 5'h00) begin
              next_msg_len = asc_byte[4:0];
            end
            next_byte_cnt = byte_cnt + 5'h01;
            next_state = (next_byte_cnt == next_msg_len) ? HSCP_ASC_CR : HSCP_ASC_HI;
          end
        end
      end
      HSCP_ASC_CR: begin
        if (rx_valid_i) begin
          next_state = (rx_byte_i == `HSCP_CHAR_CR) ? HSCP_ASC_LF : HSCP_IDLE;
        end
      end
      HSCP_ASC_LF: begin
        if (rx_valid_i) begin
          next_state = (rx_byte_i == `HSCP_CHAR_LF) ? HSCP_DISPATCH : HSCP_IDLE;
        end
      end
      HSCP_DISPATCH: begin
        // Route the command code; the handler sees only its own codes.
        next_cmd_code = msg_mem[1];
        next_cmd_len = msg_len;
        if (msg_mem[1] == `HSCP_CMD_RESET) begin
          next_state = HSCP_RESET;
        end else if (msg_mem[1] == `HSCP_CMD_FETCH) begin
          // Fetch releases a held acknowledge, if any.
          next_pending_ack = 1'b0;
          next_ack_start = pending_ack;
          next_state = pending_ack ? HSCP_ACK : HSCP_IDLE;
        end else if (is_handler_code(msg_mem[1])) begin
          next_cmd_valid = 1'b1;
          if (msg_mem[1] == `HSCP_CMD_CONFIG && msg_len >= 5'h04 &&
              msg_mem[2] == `HSCP_PROP_REPLY_ANYTIME) begin
            next_reply_anytime = (msg_mem[3] != 8'h00);
          end
          next_state = HSCP_WAIT;
        end else begin
          // Unknown code: nobody else answers, so only the acknowledge can.
          next_ack_start = reply_anytime_o;
          next_pending_ack = !reply_anytime_o;
          next_state = reply_anytime_o ? HSCP_ACK : HSCP_IDLE;
        end
      end
      HSCP_WAIT: begin
        // Bytes arriving now are dropped; framing restarts afterwards.
        if (handler_done_i) begin
          if (handler_replied_i) begin
            next_state = HSCP_IDLE;
          end else if (reply_anytime_o) begin
            next_ack_start = 1'b1;
            next_state = HSCP_ACK;
          end else begin
            next_pending_ack = 1'b1;
            next_state = HSCP_IDLE;
          end
        end
      end
      HSCP_ACK: begin
        if (ack_done) begin
          next_state = HSCP_IDLE;
        end
      end
      HSCP_RESET: begin
        // Full reset: pulse out and restore every setting to its default.
        next_soft_reset = 1'b1;
        next_pending_ack = 1'b0;
        next_reply_anytime = `HSCP_REPLY_DEFAULT;
        next_state = HSCP_IDLE;
      end
      default: begin
        next_state = HSCP_IDLE;
      end
    endcase
    next_rts = is_busy(next_state);
  end

  // Register parser state and registered outputs.
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state <= HSCP_IDLE;
      byte_cnt <= 5'h00;
      char_cnt <= 6'h00;
      msg_len <= 5'h00;
      hi_nib <= 4'h0;
      pending_ack <= 1'b0;
      reply_anytime_o <= `HSCP_REPLY_DEFAULT;
      cmd_valid_o <= 1'b0;
      cmd_code_o <= 8'h00;
      cmd_len_o <= 5'h00;
      soft_reset_o <= 1'b0;
      rts_o <= 1'b0;
      ack_start <= 1'b0;
    end else begin
      state <= next_state;
      byte_cnt <= next_byte_cnt;
      char_cnt <= next_char_cnt;
      msg_len <= next_msg_len;
      hi_nib <= next_hi_nib;
      pending_ack <= next_pending_ack;
      reply_anytime_o <= next_reply_anytime;
      cmd_valid_o <= next_cmd_valid;
      cmd_code_o <= next_cmd_code;
      cmd_len_o <= next_cmd_len;
      soft_reset_o <= next_soft_reset;
      rts_o <= next_rts;
      ack_start <= next_ack_start;
    end
  end

  // Message store and handler read port; contents need no reset.
  always_ff @(posedge core_clk_i) begin
    if (wr_en) begin
      msg_mem[byte_cnt] <= wr_data;
    end
    rd_data_o <= (rd_addr_i <= 5'h15) ? msg_mem[rd_addr_i] : 8'h00;
  end

  // A zero length byte is followed by the reset state and then the pulse.
  sequence s_reset_pulse;
    state == HSCP_RESET ##1 soft_reset_o;
  endsequence

  AST_ZERO_LEN: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == HSCP_IDLE && rx_valid_i && rx_byte_i == 8'h00 |=> s_reset_pulse)
    else $error("Zero length byte did not reset at once.");

  AST_RESET_CODE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == HSCP_DISPATCH && msg_mem[1] == `HSCP_CMD_RESET |=> s_reset_pulse)
    else $error("Reset code did not reset.");

  AST_RTS_HELD: assert property (@(posedge core_clk_i) disable iff (reset_i)
    cmd_valid_o && !handler_done_i |-> rts_o ##1 (!cmd_valid_o && rts_o))
    else $error("RTS low or second command during processing.");

  AST_BIN_LEN: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == HSCP_BIN |-> msg_len <= `HSCP_MAX_BIN_LEN && msg_len >= `HSCP_MIN_LEN)
    else $error("Binary message length out of range.");

  AST_ASC_CHARS: assert property (@(posedge core_clk_i) disable iff (reset_i)
    char_cnt <= `HSCP_MAX_ASC_CHARS)
    else $error("ASCII message exceeded its character limit.");

  AST_LF_ENDS: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == HSCP_ASC_LF && rx_valid_i && rx_byte_i == `HSCP_CHAR_LF
    |=> state == HSCP_DISPATCH && rts_o)
    else $error("CR LF did not end the ASCII message.");

  AST_LOWER_HEX: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == HSCP_ASC_HI && rx_valid_i && rx_byte_i == 8'h61 && char_cnt < 6'h30
    |=> state == HSCP_ASC_LO && hi_nib == 4'hA)
    else $error("Lower-case hex digit was not accepted.");

  AST_DEFAULT_ACK: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == HSCP_WAIT && handler_done_i && !handler_replied_i && reply_anytime_o
    |=> state == HSCP_ACK ##[1:3] tx_valid_o)
    else $error("Acknowledge not sent when no reply was given.");

  AST_FETCH: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == HSCP_DISPATCH && msg_mem[1] == `HSCP_CMD_FETCH && pending_ack
    |=> state == HSCP_ACK && !pending_ack)
    else $error("Fetch did not release the held acknowledge.");

  AST_BUSY_IGNORE: assert property (@(posedge core_clk_i) disable iff (reset_i)
    state == HSCP_WAIT && !handler_done_i |=> state == HSCP_WAIT)
    else $error("Bytes were taken while a command was in progress.");
endmodule

// ### test/hscp_host_model.sv
// Purpose: Host model that sends command bytes and takes the parser's replies.
// Assumes: One byte per clock pulse on the receive stream, replies by valid/ready.
// Notes: Ready stalls at random so the reply path sees back-pressure.
`timescale 1ns/100ps
module hscp_host_model (
  // Clock.
  input wire logic core_clk_i,
  // Flow control and replies from the parser.
  input wire logic rts_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  // Bytes and ready towards the parser.
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o,
  output logic tx_ready_o
);
  logic [7:0] tx_q[$]; // Reply bytes taken so far.
  int late; // Cycles spent waiting for the parser to free up.

  // Idle levels at time zero.
  initial begin
    rx_byte_o = 8'h00;
    rx_valid_o = 1'b0;
    tx_ready_o = 1'b0;
  end

  // A byte is taken on an edge where valid and ready are both high.
  always @(posedge core_clk_i) begin
    if (tx_valid_i === 1'b1 && tx_ready_o) begin
      tx_q.push_back(tx_data_i);
    end
    #10 tx_ready_o = ($urandom % 3) != 0;
  end

  // Sends one message back to back; waits for RTS low unless told to push in.
  task automatic send(input logic [7:0] msg[$], input bit push_in);
    late = 0;
    while (!push_in && rts_i !== 1'b0 && late < 200) begin
      @(posedge core_clk_i);
      late++;
    end
    foreach (msg[i]) begin
      @(posedge core_clk_i);
      #10;
      rx_byte_o = msg[i];
      rx_valid_o = 1'b1;
    end
    @(posedge core_clk_i);
    #10;
    rx_valid_o = 1'b0;
    // The released line must not keep showing the last byte.
    rx_byte_o = ~rx_byte_o;
  endtask
endmodule

// ### test/test_host_serial_command_parser.sv
// Purpose: Self-checking bench for the host serial command parser.
// Assumes: The bench plays the command handler; the host model drives bytes.
// Notes: A queue-based reference decides replies, dispatches and resets.
`timescale 1ns/100ps
module test_host_serial_command_parser;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic handler_done_i = 1'b0;
  logic handler_replied_i = 1'b0;
  logic [4:0] rd_addr_i = 5'h00;
  logic [7:0] rx_byte, tx_data, cmd_code, rd_data;
  logic rx_valid, tx_ready, tx_valid, cmd_valid, anytime, soft_reset, rts;
  logic [4:0] cmd_len;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int resets = 0; // Soft reset pulses seen.
  int ref_anytime = 1; // Reference reply-anytime property.
  int ref_pending = 0; // Reference held acknowledge.
  logic [7:0] exp_tx[$];
  logic [7:0] m[$];

  always #50 core_clk_i = ~core_clk_i;

  hscp_parser dut (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .rx_byte_i(rx_byte),
    .rx_valid_i(rx_valid), .handler_done_i(handler_done_i),
    .handler_replied_i(handler_replied_i), .rd_addr_i(rd_addr_i),
    .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .cmd_len_o(cmd_len),
    .rd_data_o(rd_data), .reply_anytime_o(anytime), .soft_reset_o(soft_reset),
    .rts_o(rts), .tx_ready_i(tx_ready), .tx_data_o(tx_data), .tx_valid_o(tx_valid)
  );

  hscp_host_model host (
    .core_clk_i(core_clk_i), .rts_i(rts), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .tx_ready_o(tx_ready)
  );

  // Counts reset pulses and cuts a hang short.
  always @(posedge core_clk_i) begin
    cycles++;
    if (soft_reset === 1'b1) resets++;
    if (cycles == 30000) begin
      fail_count++;
      finish_test();
    end
  end

  // Compares one byte-wide value.
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Compares a count kept by the bench.
  task automatic cmp_count(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Hex digit character, letter case chosen at random.
  function automatic logic [7:0] hexc(input logic [3:0] n);
    if (n < 4'hA) return 8'h30 + 8'(n);
    return (($urandom % 2) ? 8'h41 : 8'h61) + 8'(n) - 8'h0A;
  endfunction

  // Acknowledge goes out now, or is held for a fetch when replies wait.
  task automatic ack();
    if (ref_anytime != 0) exp_tx = '{8'h02, 8'h01};
    else ref_pending = 1;
  endtask

  // Sends one message, plays the handler, and checks every result.
  task automatic run(input bit asc, input bit replied, input bit busy);
    logic [7:0] w[$];
    int r0;
    int n;
    int len;
    int code;
    int rst;
    r0 = resets;
    len = m[0];
    code = (m.size() > 1) ? m[1] : 0;
    rst = (len == 0 || code == 0);
    exp_tx = {};
    if (rst) begin
      ref_anytime = 1;
      ref_pending = 0;
    end else if (code == 1 && len >= 4 && m[2] == 8'h09) begin
      ref_anytime = (m[3] != 0);
    end
    if (!rst && code > 15 && code != 64) ack();
    if (code == 64 && ref_pending != 0) begin
      exp_tx = '{8'h02, 8'h01};
      ref_pending = 0;
    end
    w = m;
    if (asc) begin
      w = {};
      foreach (m[i]) begin
        w.push_back(hexc(m[i][7:4]));
        w.push_back(hexc(m[i][3:0]));
      end
      if (len != 0) w.push_back(8'h0D);
      if (len != 0) w.push_back(8'h0A);
    end
    host.send(w, 1'b0);
    if (!rst && code <= 15) begin
      n = 0;
      while (cmd_valid !== 1'b1 && n < 40) begin
        @(negedge core_clk_i);
        n++;
      end
      cmp_byte({7'h00, cmd_valid}, 8'h01);
      cmp_byte(cmd_code, m[1]);
      cmp_byte({3'h0, cmd_len}, m[0]);
      cmp_byte({7'h00, rts}, 8'h01);
      // A pushed-in reset frame while busy must be dropped.
      if (busy) host.send('{8'h02, 8'h00}, 1'b1);
      @(posedge core_clk_i);
      #10 rd_addr_i = 5'(len - 1);
      @(posedge core_clk_i);
      @(negedge core_clk_i);
      cmp_byte(rd_data, m[len - 1]);
      @(posedge core_clk_i);
      #10 handler_done_i = 1'b1;
      handler_replied_i = replied;
      @(posedge core_clk_i);
      #10 handler_done_i = 1'b0;
      if (!replied) ack();
    end
    repeat (3) @(negedge core_clk_i);
    n = 0;
    while (rts !== 1'b0 && n < 80) begin
      @(negedge core_clk_i);
      n++;
    end
    cmp_count(n < 80, 1);
    repeat (3) @(negedge core_clk_i);
    cmp_count(host.tx_q.size(), exp_tx.size());
    foreach (exp_tx[i]) if (i < host.tx_q.size()) cmp_byte(host.tx_q[i], exp_tx[i]);
    cmp_count(resets - r0, rst);
    cmp_byte({7'h00, anytime}, 8'(ref_anytime));
    host.tx_q = {};
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    void'($urandom(83901));
    repeat (12) @(posedge core_clk_i);
    #10 reset_i = 1'b0;
    @(negedge core_clk_i);
    cmp_byte({6'h00, anytime, rts}, 8'h02);
    m = '{8'h03, 8'h07, 8'hAA};
    run(1'b0, 1'b0, 1'b0);
    m = '{8'h03, 8'h0A, 8'hBB};
    run(1'b1, 1'b1, 1'b0);
    $display("test framing done");
    m = '{8'h04, 8'h01, 8'h09, 8'h00};
    run(1'b1, 1'b1, 1'b0);
    m = '{8'h02, 8'h05};
    run(1'b0, 1'b0, 1'b0);
    m = '{8'h02, 8'h40};
    run(1'b1, 1'b0, 1'b0);
    m = '{8'h04, 8'h01, 8'h09, 8'h00};
    run(1'b0, 1'b1, 1'b0);
    m = '{8'h00};
    run(1'b0, 1'b0, 1'b0);
    $display("test held reply done");
    m = '{8'h02, 8'h03};
    run(1'b0, 1'b0, 1'b1);
    m = '{8'h02, 8'h20};
    run(1'b1, 1'b0, 1'b0);
    m = '{8'h02, 8'h00};
    run(1'b1, 1'b0, 1'b0);
    m = '{8'h00};
    run(1'b1, 1'b0, 1'b0);
    $display("test resets done");
    for (int c = 1; c <= 15; c++) begin
      m = '{8'h00, 8'(c)};
      repeat ((c == 15) ? 20 : 1 + $urandom % 20) m.push_back(8'($urandom));
      m[0] = 8'(m.size());
      if (c == 1) m[2] = 8'h00;
      run($urandom % 2, $urandom % 2, 1'b0);
    end
    $display("test code sweep done");
    finish_test();
  end
endmodule
